/* rtl/rfop_pkg.sv */
// package: register map, field layout and drive level codes
package rfop_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OV_MODE_HIGH = 8'h30;
    localparam logic [7:0] OFS_OV_LOW       = 8'h31;
    localparam logic [7:0] OFS_UN_MODE_HIGH = 8'h32;
    localparam logic [7:0] OFS_UN_LOW       = 8'h33;
    localparam logic [7:0] OFS_CONTROL      = 8'h40;
    localparam logic [7:0] OFS_STATUS       = 8'h41;
    localparam logic [7:0] REG_RESET        = 8'h00;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CELLS       = 14;
    localparam int HIGH_CELLS  = 6;
    localparam int MODE_LSB    = 6;
    localparam int CTL_AM_SEL  = 0;
    localparam int CTL_MOD_ACT = 1;
    localparam logic [3:0] LAST_CELL = 4'hD;
    // ------------------------------------------------------------
    // drive levels
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RFOP_LVL_DRIVER = 2'h0,
        RFOP_LVL_AM     = 2'h1,
        RFOP_LVL_STOP   = 2'h2,
        RFOP_LVL_RSVD   = 2'h3
    } rfop_level_t;
    // drive request handed to the transmitter
    typedef struct packed {
        logic        active;
        rfop_level_t level;
    } rfop_drive_t;
    // one protection pattern with its level select
    typedef struct packed {
        logic [CELLS-1:0] cells;
        rfop_level_t      sel;
    } rfop_cfg_t;
endpackage

/* rtl/rfop_seq.sv */
// module: cell sequencer for one protection window
`timescale 1ns/10ps
module rfop_seq (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // window and configuration
    input  wire logic                  start,
    input  wire rfop_pkg::rfop_cfg_t   cfg,
    input  wire logic                  am_sel,
    // drive request
    output rfop_pkg::rfop_drive_t      drive
);
    typedef enum logic [1:0] {
        RFOP_S_IDLE = 2'b01,
        RFOP_S_RUN  = 2'b10
    } rfop_seq_st_t;
    rfop_seq_st_t st_r;
    rfop_seq_st_t st_nxt;
    logic [3:0]   idx_r;
    logic [3:0]   idx_nxt;
    logic         cell_on;
    logic [1:0]   lvl_w;
    // ------------------------------------------------------------
    // level choice for the current cell
    // ------------------------------------------------------------
    assign cell_on = cfg.cells[idx_r];
    // select field only counts while the regulator select is low
    assign lvl_w = am_sel ? {1'b0, cell_on} : cfg.sel;
    // ------------------------------------------------------------
    // one cell per carrier period, stop after the last cell
    // ------------------------------------------------------------
    always_comb begin
        st_nxt  = st_r;
        idx_nxt = idx_r;
        case (st_r)
            RFOP_S_IDLE: begin
                if (start) begin
                    st_nxt  = RFOP_S_RUN;
                    idx_nxt = 4'h0;
                end
            end
            RFOP_S_RUN: begin
                if (idx_r == rfop_pkg::LAST_CELL) begin
                    st_nxt  = RFOP_S_IDLE;
                    idx_nxt = 4'h0;
                end else begin
                    idx_nxt = idx_r + 4'h1;
                end
            end
            default: begin
                st_nxt  = RFOP_S_IDLE;
                idx_nxt = 4'h0;
            end
        endcase
    end
    // state and output registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r  <= RFOP_S_IDLE;
            idx_r <= 4'h0;
            drive <= '0;
        end else begin
            st_r         <= st_nxt;
            idx_r        <= idx_nxt;
            drive.active <= (st_r == RFOP_S_RUN) && cell_on;
            drive.level  <= rfop_pkg::rfop_level_t'(lvl_w);
        end
    end
endmodule

/* rtl/rfop_top.sv */
// module: overshoot and undershoot protection pattern block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
module rfop_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // window starts from the modulator
    input  wire logic        mod_start,
    input  wire logic        mod_end,
    // transmitter drive
    output logic             ov_active,
    output logic [1:0]       ov_level,
    output logic             un_active,
    output logic [1:0]       un_level
);
    logic [7:0] ov_high_r;
    logic [7:0] ov_low_r;
    logic [7:0] un_high_r;
    logic [7:0] un_low_r;
    logic [7:0] ctl_r;
    logic [7:0] rd_nxt;
    logic       mod_act_r;
    logic       mod_act_nxt;
    logic       am_sel;
    rfop_pkg::rfop_cfg_t   ov_cfg;
    rfop_pkg::rfop_cfg_t   un_cfg;
    rfop_pkg::rfop_drive_t ov_drv;
    rfop_pkg::rfop_drive_t un_drv;
    // ------------------------------------------------------------
    // pattern assembly
    // ------------------------------------------------------------
    assign am_sel = ctl_r[rfop_pkg::CTL_AM_SEL];
    // select in bits 7..6, high cells in bits 5..0
    assign ov_cfg.cells = {ov_high_r[rfop_pkg::HIGH_CELLS-1:0],
                           ov_low_r};
    assign ov_cfg.sel = rfop_pkg::rfop_level_t'(
                        ov_high_r[rfop_pkg::MODE_LSB+:2]);
    assign un_cfg.cells = {un_high_r[rfop_pkg::HIGH_CELLS-1:0],
                           un_low_r};
    assign un_cfg.sel = rfop_pkg::rfop_level_t'(
                        un_high_r[rfop_pkg::MODE_LSB+:2]);
    // modulation window tracking; end wins over a new start
    assign mod_act_nxt = mod_end ? 1'b0 : (mod_start ? 1'b1 : mod_act_r);
    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            rfop_pkg::OFS_OV_MODE_HIGH: rd_nxt = ov_high_r;
            rfop_pkg::OFS_OV_LOW:       rd_nxt = ov_low_r;
            rfop_pkg::OFS_UN_MODE_HIGH: rd_nxt = un_high_r;
            rfop_pkg::OFS_UN_LOW:       rd_nxt = un_low_r;
            rfop_pkg::OFS_CONTROL:      rd_nxt = {7'h00, ctl_r[0]};
            rfop_pkg::OFS_STATUS:       rd_nxt = {5'h00, un_active,
                                                  ov_active, mod_act_r};
            default:                    rd_nxt = 8'h00;
        endcase
    end
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ov_high_r <= rfop_pkg::REG_RESET;
            ov_low_r  <= rfop_pkg::REG_RESET;
            un_high_r <= rfop_pkg::REG_RESET;
            un_low_r  <= rfop_pkg::REG_RESET;
            ctl_r     <= rfop_pkg::REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                rfop_pkg::OFS_OV_MODE_HIGH: ov_high_r <= reg_wdata;
                rfop_pkg::OFS_OV_LOW:       ov_low_r  <= reg_wdata;
                rfop_pkg::OFS_UN_MODE_HIGH: un_high_r <= reg_wdata;
                rfop_pkg::OFS_UN_LOW:       un_low_r  <= reg_wdata;
                rfop_pkg::OFS_CONTROL:      ctl_r <= {7'h00, reg_wdata[0]};
                default:                    ctl_r <= ctl_r;
            endcase
        end
    end
    // read data stands one cycle after the strobe only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            mod_act_r <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rd_nxt : 8'h00;
            mod_act_r <= mod_act_nxt;
        end
    end
    // ------------------------------------------------------------
    // sequencers: overshoot in the window, undershoot after it
    // ------------------------------------------------------------
    rfop_seq u_ov (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (mod_start),
        .cfg     (ov_cfg),
        .am_sel  (am_sel),
        .drive   (ov_drv)
    );
    rfop_seq u_un (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (mod_end),
        .cfg     (un_cfg),
        .am_sel  (am_sel),
        .drive   (un_drv)
    );
    // output flops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ov_active <= 1'b0;
            ov_level  <= 2'h0;
            un_active <= 1'b0;
            un_level  <= 2'h0;
        end else begin
            ov_active <= ov_drv.active;
            ov_level  <= ov_drv.level;
            un_active <= un_drv.active;
            un_level  <= un_drv.level;
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_ov_cell;
        @(posedge clk_sys) disable iff (rst)
        mod_start |-> ##2 (ov_drv.active == $past(ov_cfg.cells[0], 1));
    endproperty
    a_ov_cell: assert property (p_ov_cell)
        else $error("overshoot cell 0 not applied");
    property p_un_cell;
        @(posedge clk_sys) disable iff (rst)
        mod_end ##1 !rst |-> ##1 (un_drv.active == $past(un_cfg.cells[0]));
    endproperty
    a_un_cell: assert property (p_un_cell)
        else $error("undershoot cell 0 not applied");
    property p_ov_field;
        @(posedge clk_sys) disable iff (rst)
        ($past(!am_sel) && ov_drv.active) |->
            ov_drv.level == $past(ov_cfg.sel);
    endproperty
    a_ov_field: assert property (p_ov_field)
        else $error("overshoot level not from select field");
    property p_ov_cellval;
        @(posedge clk_sys) disable iff (rst)
        ($past(am_sel) && ov_drv.active) |->
            ov_drv.level == rfop_pkg::RFOP_LVL_AM;
    endproperty
    a_ov_cellval: assert property (p_ov_cellval)
        else $error("overshoot level not from cell value");
    property p_un_field;
        @(posedge clk_sys) disable iff (rst)
        ($past(!am_sel) && un_drv.active) |->
            un_drv.level == $past(un_cfg.sel);
    endproperty
    a_un_field: assert property (p_un_field)
        else $error("undershoot level not from select field");
    property p_un_cellval;
        @(posedge clk_sys) disable iff (rst)
        ($past(am_sel) && un_drv.active) |->
            un_drv.level == rfop_pkg::RFOP_LVL_AM;
    endproperty
    a_un_cellval: assert property (p_un_cellval)
        else $error("undershoot level not from cell value");
    property p_un_ignore;
        @(posedge clk_sys) disable iff (rst)
        $past(am_sel) |-> un_drv.level != rfop_pkg::RFOP_LVL_STOP;
    endproperty
    a_un_ignore: assert property (p_un_ignore)
        else $error("undershoot select honoured with regulator select");
    property p_ov_ignore;
        @(posedge clk_sys) disable iff (rst)
        $past(am_sel) |-> ov_drv.level[1] == 1'b0;
    endproperty
    a_ov_ignore: assert property (p_ov_ignore)
        else $error("overshoot select honoured with regulator select");
    property p_stop;
        @(posedge clk_sys) disable iff (rst)
        (mod_start && !u_ov.st_r[1]) ##1 (!mod_start)[*8] ##1 1 ##1 1
            ##1 1 ##1 1 ##1 1 ##1 1 |-> ##2 !ov_drv.active;
    endproperty
    a_stop: assert property (p_stop)
        else $error("overshoot drive past last cell");
    property p_wr_un;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == rfop_pkg::OFS_UN_MODE_HIGH) |=>
            un_cfg.cells[13:8] == $past(reg_wdata[5:0]);
    endproperty
    a_wr_un: assert property (p_wr_un)
        else $error("undershoot high cells not stored");
    property p_wr_ov;
        @(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == rfop_pkg::OFS_OV_MODE_HIGH) |=>
            ov_cfg.sel == $past(reg_wdata[7:6]);
    endproperty
    a_wr_ov: assert property (p_wr_ov)
        else $error("overshoot select not stored");
endmodule

/* test/tb_rfop_top.sv */
// testbench: register access and protection window drive checks
`timescale 1ns/10ps
module tb_rfop_top;
    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    logic       clk_sys   = 1'b0;
    logic       rst       = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [7:0] reg_rdata;
    logic       mod_start = 1'b0;
    logic       mod_end   = 1'b0;
    logic       ov_active;
    logic [1:0] ov_level;
    logic       un_active;
    logic [1:0] un_level;
    int         mismatches = 0;
    int         n_compared = 0;

    rfop_top dut_u (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .reg_addr (reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .reg_rdata(reg_rdata),
        .mod_start(mod_start),
        .mod_end  (mod_end),
        .ov_active(ov_active),
        .ov_level (ov_level),
        .un_active(un_active),
        .un_level (un_level)
    );

    // 50 MHz carrier clock
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    // one-cycle write strobe, released at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp, "read data");
    endtask

    // load one pattern, its level select and the regulator select
    task automatic cfg(input logic un, input logic [13:0] c,
                       input logic [1:0] sel, input logic am);
        logic [7:0] hi;
        hi = un ? rfop_pkg::OFS_UN_MODE_HIGH : rfop_pkg::OFS_OV_MODE_HIGH;
        wr(hi, {sel, c[13:8]});
        wr(hi + 8'h01, c[7:0]);
        wr(rfop_pkg::OFS_CONTROL, {7'h00, am});
        rd(hi, {sel, c[13:8]});
        rd(hi + 8'h01, c[7:0]);
    endtask

    // start a window; cell k shows k+3 edges after the start edge
    task automatic win(input logic un, input logic [13:0] c,
                       input logic [1:0] sel, input logic am);
        logic       act;
        logic [1:0] lvl;
        @(posedge clk_sys);
        mod_start <= !un;
        mod_end   <= un;
        @(posedge clk_sys);
        mod_start <= 1'b0;
        mod_end   <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // two cells past the last one must stay quiet
        for (int k = 0; k < 16; k++) begin
            #1;
            act = (k < 14) ? c[k] : 1'b0;
            lvl = am ? {1'b0, act} : sel;
            chk({7'h0, un ? un_active : ov_active}, {7'h0, act}, "act");
            chk({7'h0, un ? ov_active : un_active}, 8'h00, "idle");
            if (act) chk({6'h0, un ? un_level : ov_level}, {6'h0, lvl}, "lvl");
            @(posedge clk_sys);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        // cleared registers and an idle window
        rd(rfop_pkg::OFS_OV_MODE_HIGH, 8'h00);
        rd(rfop_pkg::OFS_OV_LOW, 8'h00);
        rd(rfop_pkg::OFS_UN_MODE_HIGH, 8'h00);
        rd(rfop_pkg::OFS_UN_LOW, 8'h00);
        rd(8'h7F, 8'h00);
        wr(rfop_pkg::OFS_STATUS, 8'hFF);
        rd(rfop_pkg::OFS_STATUS, 8'h00);
        win(1'b0, 14'h0000, 2'h0, 1'b0);
        // every level code, first and last cells set
        for (int s = 0; s < 4; s++) begin
            cfg(1'b0, 14'h2C35, s[1:0], 1'b0);
            win(1'b0, 14'h2C35, s[1:0], 1'b0);
            cfg(1'b1, 14'h3093, s[1:0], 1'b0);
            win(1'b1, 14'h3093, s[1:0], 1'b0);
        end
        // regulator select set: cell value picks the level
        cfg(1'b0, 14'h1ACB, 2'h2, 1'b1);
        win(1'b0, 14'h1ACB, 2'h2, 1'b1);
        cfg(1'b1, 14'h2D34, 2'h3, 1'b1);
        win(1'b1, 14'h2D34, 2'h3, 1'b1);
        rd(rfop_pkg::OFS_CONTROL, 8'h01);
        close_out;
    end

    // hang guard, far beyond the planned run length
    initial begin
        #1000000;
        mismatches++;
        close_out;
    end
endmodule
